// [design/angle_spi_map.vh]
/*
 * constants for the angle sensor spi target port: primary offsets,
 * frame field positions, reset values and crc settings.
 * assumes it is included by its bare name from the design file.
 */
`ifndef ANGLE_SPI_MAP_VH
`define ANGLE_SPI_MAP_VH

// primary register offsets (5-bit)
`define OFS_EXT_WR_TARGET 5'h01
`define OFS_EXT_WR_HIGH 5'h02
`define OFS_EXT_WR_LOW 5'h03
`define OFS_EXT_WR_CMD 5'h04
`define OFS_EXT_RD_TARGET 5'h05
`define OFS_EXT_RD_CMD 5'h06
`define OFS_EXT_RD_HIGH 5'h07
`define OFS_EXT_RD_LOW 5'h08
`define OFS_ANGLE_STATUS 5'h0c
`define OFS_ANGLE_MAIN 5'h0e
`define OFS_ERROR_WORD 5'h0f
// pseudo addresses reported after a write or a bad frame
`define OFS_AFTER_WRITE 5'h10
`define OFS_AFTER_BAD_CRC 5'h11

// command frame fields
`define CMD_RW_BIT 30
`define CMD_ADDR_HI 29
`define CMD_ADDR_LO 25
`define CMD_DATA_HI 21
`define CMD_DATA_LO 6
`define FRAME_BITS 6'h20

// extended command/state register fields
`define XCMD_START_BIT 0
`define XCMD_DONE_BIT 1
`define XCMD_BUSY_BIT 15

// angle status register field
`define ANGLE_RDY_BIT 0

// reset values
`define RST_REG16 16'h0000
`define RST_ADDR5 5'h00
`define RST_COUNT3 3'h0

// crc: x^5 + x^2 + 1, seeded all ones
`define CRC_SEED 5'h1f
`define CRC_POLY 5'h05

`endif

// [design/angle_spi_port.v]
/*
 * spi target port of the angle sensor: mode 3 sampling of the pins,
 * 32-bit frame receive and transmit, crc check and generation, the
 * primary register bank with indirect extended-memory registers.
 * assumes sclk, cs_n and mosi come from an outside controller and are
 * asynchronous to clk; the extended memory and angle logic sit on clk.
 */
// Functional notes
// - full duplex spi mode 3
// - one 32-bit msb-first frame per select
// - command bit 30: one write, zero read
// - bits 29:25 give primary register address
// - write stores bits 21:6, read ignores them
// - command crc covers bits 30:5
// - response bit 31 fixed one
// - response 30:26 echo previous read address
// - response 25:23 three-bit frame counter
// - bit 22 sticky or of unmasked errors
// - bit 5 same sticky error or, also set after bad crc
// - response 21:6 addressed register contents
// - response crc covers bits 30:5
// - crc x^5+x^2+1 seeded all ones
// - bad crc frame causes no access
// - extended access goes through primary registers
// - extended write uses offsets 1 to 4
// - extended read uses 5,6 then 7,8
// - after bad crc: addr 0x11, errors, bit5
// - after write: addr 0x10, main angle
// - status ones until ready and first read
`timescale 1ns/10ps
`default_nettype none
`include "angle_spi_map.vh"

module angle_spi_port
(
  // clock and reset
  input wire clk,
  input wire reset,
  // spi pins
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  output reg miso,
  output reg miso_oe,
  // angle and error sources
  input wire [15:0] angle_main,
  input wire [15:0] angle_status,
  input wire [15:0] error_word,
  input wire error_active,
  input wire slew_limit_error,
  // extended memory side
  output reg ext_wr_req,
  output reg [15:0] ext_wr_addr,
  output reg [31:0] ext_wr_data,
  input wire ext_wr_done,
  output reg ext_rd_req,
  output reg [15:0] ext_rd_addr,
  input wire ext_rd_done,
  input wire [31:0] ext_rd_data
);

  // serial crc over a 26-bit field, msb first
  function [4:0] crc26;
    input [25:0] bits;
    reg [4:0] c;
    reg fb;
    integer i;
    begin
      c = `CRC_SEED;
      for (i = 25; i >= 0; i = i - 1)
      begin
        fb = c[4] ^ bits[i];
        c = {c[3:0], 1'b0} ^ (fb ? `CRC_POLY : 5'h00);
      end
      crc26 = c;
    end
  endfunction

  // two-stage synchronisers for the pins
  reg sclk_s1_r, sclk_s2_r, sclk_s3_r;
  reg cs_s1_r, cs_s2_r, cs_s3_r;
  reg mosi_s1_r, mosi_s2_r;

  // receive and transmit shift state
  reg [31:0] rx_r; // incoming bits
  reg [5:0] bit_cnt_r; // rising edges seen this frame
  reg [31:0] tx_r; // outgoing bits still to drive

  // response context left by the last completed frame
  reg [4:0] resp_addr_r; // address the next response reports
  reg bad_crc_r; // last frame failed its check
  reg [2:0] frame_cnt_r; // frames exchanged
  reg status_r; // sticky error indication
  reg por_r; // power-on status still pending
  reg presented_r; // status value shown in the current response

  // primary registers
  reg [15:0] wr_target_r, wr_high_r, wr_low_r;
  reg [15:0] rd_target_r, rd_high_r, rd_low_r;
  reg wr_busy_r, wr_done_r, rd_busy_r, rd_done_r;

  // edge detects, taken only from settled synchroniser stages
  wire sclk_rise = sclk_s2_r & ~sclk_s3_r; // capture edge in mode 3
  wire sclk_fall = ~sclk_s2_r & sclk_s3_r; // launch edge in mode 3
  wire cs_fall = ~cs_s2_r & cs_s3_r;
  wire selected = ~cs_s2_r;

  // frame completes on the 32nd capture edge while selected
  wire frame_end = selected & sclk_rise & (bit_cnt_r == `FRAME_BITS - 6'h01);
  wire [31:0] frame = {rx_r[30:0], mosi_s2_r};
  wire crc_ok = (crc26(frame[30:5]) == frame[4:0]);
  wire is_write = frame[`CMD_RW_BIT];
  wire [4:0] cmd_addr = frame[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire [15:0] cmd_data = frame[`CMD_DATA_HI:`CMD_DATA_LO];
  // bit 31 never feeds any decision; bits 24:22 and 5 only enter the crc check
  wire good_frame = frame_end & crc_ok;
  wire good_write = good_frame & is_write;
  wire good_read = good_frame & ~is_write;
  wire err_cond = error_active | slew_limit_error;
  wire angle_ready = angle_status[`ANGLE_RDY_BIT];

  // contents of a primary register, read at response load time
  reg [15:0] rd_mux;
  always @*
  begin
    case (resp_addr_r)
      `OFS_EXT_WR_TARGET: rd_mux = wr_target_r;
      `OFS_EXT_WR_HIGH: rd_mux = wr_high_r;
      `OFS_EXT_WR_LOW: rd_mux = wr_low_r;
      `OFS_EXT_WR_CMD: rd_mux = {wr_busy_r, 13'h0000, wr_done_r, 1'b0};
      `OFS_EXT_RD_TARGET: rd_mux = rd_target_r;
      `OFS_EXT_RD_CMD: rd_mux = {rd_busy_r, 13'h0000, rd_done_r, 1'b0};
      `OFS_EXT_RD_HIGH: rd_mux = rd_high_r;
      `OFS_EXT_RD_LOW: rd_mux = rd_low_r;
      `OFS_ANGLE_STATUS: rd_mux = angle_status;
      `OFS_ANGLE_MAIN: rd_mux = angle_main;
      `OFS_AFTER_WRITE: rd_mux = angle_main;
      `OFS_ERROR_WORD: rd_mux = error_word;
      `OFS_AFTER_BAD_CRC: rd_mux = error_word;
      default: rd_mux = 16'h0000; // unmapped locations read zero
    endcase
  end

  // response word assembled from the stored context
  wire shown = por_r | status_r;
  wire [25:0] resp_body = {resp_addr_r, frame_cnt_r, shown, rd_mux,
                           shown | bad_crc_r};
  wire [31:0] resp_word = {1'b1, resp_body, crc26(resp_body)};

  // pin synchronisers; the first stage feeds only the second
  always @(posedge clk)
  begin
    if (reset)
    begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
    end
    else
    begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      mosi_s1_r <= mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end

  // receive shifter; deselect throws away a partial frame
  always @(posedge clk)
  begin
    if (reset)
    begin
      rx_r <= 32'h00000000;
      bit_cnt_r <= 6'h00;
    end
    else if (!selected)
    begin
      bit_cnt_r <= 6'h00;
    end
    else if (sclk_rise && bit_cnt_r != `FRAME_BITS)
    begin
      rx_r <= frame;
      bit_cnt_r <= bit_cnt_r + 6'h01; // extra clocks past 32 are ignored
    end
  end

  // transmit shifter; bit 31 is put out at select so it is valid early
  always @(posedge clk)
  begin
    if (reset)
    begin
      tx_r <= 32'h00000000;
      miso <= 1'b0;
      miso_oe <= 1'b0;
      presented_r <= 1'b0;
    end
    else
    begin
      miso_oe <= selected;
      if (cs_fall)
      begin
        miso <= resp_word[31];
        tx_r <= {resp_word[30:0], 1'b0};
        presented_r <= shown;
      end
      else if (selected && sclk_fall && bit_cnt_r != 6'h00)
      begin
        // first falling edge only opens the frame; later ones advance it
        miso <= tx_r[31];
        tx_r <= {tx_r[30:0], 1'b0};
      end
    end
  end

  // response context, frame counter and status flags
  always @(posedge clk)
  begin
    if (reset)
    begin
      resp_addr_r <= `RST_ADDR5;
      bad_crc_r <= 1'b0;
      frame_cnt_r <= `RST_COUNT3;
      status_r <= 1'b0;
      por_r <= 1'b1;
    end
    else
    begin
      if (frame_end)
      begin
        frame_cnt_r <= frame_cnt_r + 3'h1;
        bad_crc_r <= ~crc_ok;
        if (!crc_ok)
          resp_addr_r <= `OFS_AFTER_BAD_CRC;
        else if (is_write)
          resp_addr_r <= `OFS_AFTER_WRITE;
        else
          resp_addr_r <= cmd_addr; // data follows in the next frame
      end
      // power-on ones hold until angle ready and a completed read
      if (good_read && angle_ready)
        por_r <= 1'b0;
      // a new error in the clearing cycle keeps the flag set
      if (err_cond)
        status_r <= 1'b1;
      else if (good_read && presented_r)
        status_r <= 1'b0;
    end
  end

  // primary register writes and indirect extended memory control
  always @(posedge clk)
  begin
    if (reset)
    begin
      wr_target_r <= `RST_REG16;
      wr_high_r <= `RST_REG16;
      wr_low_r <= `RST_REG16;
      rd_target_r <= `RST_REG16;
      rd_high_r <= `RST_REG16;
      rd_low_r <= `RST_REG16;
      wr_busy_r <= 1'b0;
      wr_done_r <= 1'b0;
      rd_busy_r <= 1'b0;
      rd_done_r <= 1'b0;
      ext_wr_req <= 1'b0;
      ext_wr_addr <= `RST_REG16;
      ext_wr_data <= 32'h00000000;
      ext_rd_req <= 1'b0;
      ext_rd_addr <= `RST_REG16;
    end
    else
    begin
      ext_wr_req <= 1'b0;
      ext_rd_req <= 1'b0;
      // done flags: software clears by writing one, completion wins
      if (good_write && cmd_addr == `OFS_EXT_WR_CMD && cmd_data[`XCMD_DONE_BIT])
        wr_done_r <= 1'b0;
      if (good_write && cmd_addr == `OFS_EXT_RD_CMD && cmd_data[`XCMD_DONE_BIT])
        rd_done_r <= 1'b0;
      if (good_write)
      begin
        case (cmd_addr)
          `OFS_EXT_WR_TARGET: wr_target_r <= cmd_data;
          `OFS_EXT_WR_HIGH: wr_high_r <= cmd_data;
          `OFS_EXT_WR_LOW: wr_low_r <= cmd_data;
          `OFS_EXT_RD_TARGET: rd_target_r <= cmd_data;
          `OFS_EXT_WR_CMD:
            if (cmd_data[`XCMD_START_BIT] && !wr_busy_r)
            begin
              // launch an extended write from the staged words
              ext_wr_req <= 1'b1;
              ext_wr_addr <= wr_target_r;
              ext_wr_data <= {wr_high_r, wr_low_r};
              wr_busy_r <= 1'b1;
            end
          `OFS_EXT_RD_CMD:
            if (cmd_data[`XCMD_START_BIT] && !rd_busy_r)
            begin
              ext_rd_req <= 1'b1;
              ext_rd_addr <= rd_target_r;
              rd_busy_r <= 1'b1;
            end
          default: ; // other locations are read-only here
        endcase
      end
      // completions from the extended memory side
      if (ext_wr_done)
      begin
        wr_busy_r <= 1'b0;
        wr_done_r <= 1'b1;
      end
      if (ext_rd_done)
      begin
        rd_high_r <= ext_rd_data[31:16];
        rd_low_r <= ext_rd_data[15:0];
        rd_busy_r <= 1'b0;
        rd_done_r <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [testbench/angle_spi_port_sva.sv]
/*
 * checker for the angle spi port pins and extended requests.
 * assumes it is bound to angle_spi_port and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none

module angle_spi_port_sva
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // spi pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic miso_oe,
  // extended memory requests
  input wire logic ext_wr_req,
  input wire logic [15:0] ext_wr_addr,
  input wire logic [31:0] ext_wr_data,
  input wire logic ext_rd_req,
  input wire logic [15:0] ext_rd_addr
);
  // one domain, every check sleeps through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  quiet_after_reset_a: assert property ($fell(reset) |-> !miso_oe && !ext_wr_req && !ext_rd_req)
    else $error("outputs active after reset");
  oe_released_a: assert property (cs_n [*6] |-> !miso_oe)
    else $error("miso driven while deselected");
  oe_driven_a: assert property (!cs_n [*6] |-> miso_oe)
    else $error("miso not driven while selected");
  start_bit_a: assert property ($fell(cs_n) |-> ##6 (miso_oe && miso))
    else $error("response start bit not one");
  hold_while_high_a: assert property ($rose(sclk) |-> ##2 $stable(miso) [*2])
    else $error("miso moved while sclk high");
  wr_pulse_a: assert property (ext_wr_req |=> !ext_wr_req)
    else $error("write request longer than one cycle");
  rd_pulse_a: assert property (ext_rd_req |=> !ext_rd_req)
    else $error("read request longer than one cycle");
  wr_hold_a: assert property (!ext_wr_req |-> $stable(ext_wr_addr) && $stable(ext_wr_data))
    else $error("write target moved without a start");
  rd_hold_a: assert property (!ext_rd_req |-> $stable(ext_rd_addr))
    else $error("read target moved without a start");
endmodule

bind angle_spi_port angle_spi_port_sva angle_spi_port_sva_i (.clk(clk), .reset(reset),
  .sclk(sclk), .cs_n(cs_n), .miso(miso), .miso_oe(miso_oe), .ext_wr_req(ext_wr_req),
  .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data), .ext_rd_req(ext_rd_req),
  .ext_rd_addr(ext_rd_addr));

`default_nettype wire

// [testbench/angle_spi_port_tb.sv]
/*
 * self-checking bench for the angle spi port.
 * assumes spi_ctrl_model drives the pins and the checker is bound.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module angle_spi_port_tb;
  localparam logic [15:0] ANG = 16'h5a3c; // main angle seen by reads
  localparam logic [15:0] ERR = 16'h0f0f; // error word
  logic clk, reset, error_active, slew_limit_error, ext_wr_done, ext_rd_done;
  logic [15:0] angle_main, angle_status, error_word;
  logic [31:0] ext_rd_data, resp;
  wire sclk, cs_n, mosi, miso, miso_oe, ext_wr_req, ext_rd_req;
  wire [15:0] ext_wr_addr, ext_rd_addr;
  wire [31:0] ext_wr_data;
  int mismatches, compares, wr_reqs, rd_reqs;
  logic [2:0] cnt; // expected frame count

  angle_spi_port angle_spi_port_i (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .angle_main(angle_main),
    .angle_status(angle_status), .error_word(error_word), .error_active(error_active),
    .slew_limit_error(slew_limit_error), .ext_wr_req(ext_wr_req), .ext_wr_addr(ext_wr_addr),
    .ext_wr_data(ext_wr_data), .ext_wr_done(ext_wr_done), .ext_rd_req(ext_rd_req),
    .ext_rd_addr(ext_rd_addr), .ext_rd_done(ext_rd_done), .ext_rd_data(ext_rd_data));
  spi_ctrl_model ctl_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // count request pulses; cleared by reset so only this process drives them
  always @(posedge clk)
  begin
    if (reset)
    begin
      wr_reqs <= 0;
      rd_reqs <= 0;
    end
    else
    begin
      wr_reqs <= wr_reqs + (ext_wr_req === 1'b1);
      rd_reqs <= rd_reqs + (ext_rd_req === 1'b1);
    end
  end

  // one frame; full frames have their whole response compared
  task automatic step(input logic w, input logic [4:0] a, input logic [15:0] d,
    input logic bad, input int n, input logic [4:0] ea, input logic [15:0] ed,
    input logic s1, input logic s0);
    logic [25:0] body;
    ctl_i.xfer(w, a, d, bad, n, resp);
    body = {ea, cnt, s1, ed, s0};
    if (n == 32)
    begin
      `CHK(resp, {1'b1, body, ctl_i.crc5(body)})
      cnt++;
    end
  endtask

  task automatic power_on;
    step(0, 5'h0e, 16'h0, 0, 32, 5'h00, 16'h0, 1, 1);
    step(0, 5'h0e, 16'h0, 0, 32, 5'h0e, ANG, 1, 1);
    @(posedge clk) #2 angle_status = 16'h0001;
  endtask

  task automatic write_read;
    step(1, 5'h01, 16'h1234, 0, 32, 5'h0e, ANG, 1, 1);
    step(0, 5'h01, 16'h0, 0, 32, 5'h10, ANG, 1, 1);
    step(0, 5'h0c, 16'h0, 0, 32, 5'h01, 16'h1234, 0, 0);
  endtask

  task automatic bad_frames;
    step(1, 5'h01, 16'hffff, 1, 32, 5'h0c, 16'h0001, 0, 0);
    step(0, 5'h01, 16'h0, 0, 32, 5'h11, ERR, 0, 1);
    step(1, 5'h01, 16'hffff, 0, 16, 5'h0, 16'h0, 0, 0);
    step(0, 5'h0f, 16'h0, 0, 32, 5'h01, 16'h1234, 0, 0);
  endtask

  // each error source alone sets the flags; a write frame must not clear them
  task automatic error_flags;
    @(posedge clk) #2 slew_limit_error = 1'b1;
    @(posedge clk) #2 slew_limit_error = 1'b0;
    step(0, 5'h0f, 16'h0, 0, 32, 5'h0f, ERR, 1, 1);
    @(posedge clk) #2 error_active = 1'b1;
    @(posedge clk) #2 error_active = 1'b0;
    step(1, 5'h02, 16'habcd, 0, 32, 5'h0f, ERR, 1, 1);
    step(0, 5'h0f, 16'h0, 0, 32, 5'h10, ANG, 1, 1);
  endtask

  task automatic ext_write;
    step(1, 5'h03, 16'h5678, 0, 32, 5'h0f, ERR, 0, 0);
    step(1, 5'h04, 16'h0001, 0, 32, 5'h10, ANG, 0, 0);
    // a second start while the first is still busy must be ignored
    step(1, 5'h04, 16'h0001, 0, 32, 5'h10, ANG, 0, 0);
    @(posedge clk) #2;
    `CHK(wr_reqs, 1)
    `CHK(ext_wr_addr, 16'h1234)
    `CHK(ext_wr_data, 32'habcd5678)
    ext_wr_done = 1'b1;
    @(posedge clk) #2 ext_wr_done = 1'b0;
    step(0, 5'h04, 16'h0, 0, 32, 5'h10, ANG, 0, 0);
    step(1, 5'h05, 16'h0042, 0, 32, 5'h04, 16'h0002, 0, 0);
  endtask

  task automatic ext_read;
    step(1, 5'h06, 16'h0001, 0, 32, 5'h10, ANG, 0, 0);
    @(posedge clk) #2;
    `CHK(rd_reqs, 1)
    `CHK(ext_rd_addr, 16'h0042)
    ext_rd_data = 32'hdeadbeef;
    ext_rd_done = 1'b1;
    @(posedge clk) #2 ext_rd_done = 1'b0;
    step(0, 5'h07, 16'h0, 0, 32, 5'h10, ANG, 0, 0);
    step(0, 5'h08, 16'h0, 0, 32, 5'h07, 16'hdead, 0, 0);
    step(0, 5'h00, 16'h0, 0, 32, 5'h08, 16'hbeef, 0, 0);
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {reset, error_active, slew_limit_error, ext_wr_done, ext_rd_done} = 5'h10;
    {angle_main, angle_status, error_word, ext_rd_data} = {ANG, 16'h0, ERR, 32'h0};
    {mismatches, compares, cnt} = '0;
    repeat (16) @(posedge clk);
    #2 reset = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    power_on;
    write_read;
    bad_frames;
    error_flags;
    ext_write;
    ext_read;
    complete_run;
  end

  // watchdog: about three times the expected run
  initial
  begin
    #400000;
    mismatches++;
    complete_run;
  end
endmodule

`default_nettype wire

// [testbench/spi_ctrl_model.sv]
/*
 * spi controller model: mode 3 frames of up to 32 bits with crc.
 * assumes the bench calls xfer, which leaves 300 ns idle after each.
 */
`timescale 1ns/10ps
`default_nettype none

module spi_ctrl_model
(
  // link pins
  output var logic sclk,
  output var logic cs_n,
  output var logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  // link idles high and deselected
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // crc over 26 bits, msb first
  function automatic logic [4:0] crc5(input logic [25:0] v);
    logic [4:0] c;
    c = 5'h1f;
    for (int i = 25; i >= 0; i--)
      c = {c[3:0], 1'b0} ^ ((c[4] ^ v[i]) ? 5'h05 : 5'h00);
    return c;
  endfunction

  // one frame; n below 32 aborts it early, bad spoils the crc
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                      input logic bad, input int n, output logic [31:0] r);
    logic [31:0] c;
    c = {1'b0, w, a, 3'b101, d, 1'b1, 5'h00};
    c[4:0] = crc5(c[30:5]) ^ {4'h0, bad};
    r = 32'h0;
    cs_n = 1'b0;
    #100;
    for (int k = 31; k > 31 - n; k--)
    begin
      sclk = 1'b0;
      mosi = c[k];
      #100;
      sclk = 1'b1;
      #100;
      // sampled late in the high phase, well past output valid time
      r[k] = miso_oe ? miso : 1'bx;
    end
    cs_n = 1'b1;
    // released line must not keep showing the last bit
    mosi = ~mosi;
    #300;
  endtask
endmodule

`default_nettype wire
